// >>> design/rse_log_conv.sv
module rse_log_conv #(
    parameter int AVG_W = 13
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic in_valid,
    input wire logic [AVG_W-1:0] avg,
    input wire logic [1:0] gain,
    output logic out_valid,
    output logic [7:0] strength
);
    import rse_pkg::*;

    logic out_valid_r;
    logic out_valid_nxt;
    logic [7:0] strength_r;
    logic [7:0] strength_nxt;
    logic [3:0] msb;
    logic [AVG_W-1:0] norm;
    logic [3:0] mant;
    logic [7:0] frac;
    logic [7:0] gain_comp;

    function automatic logic [3:0] msb_pos(input logic [AVG_W-1:0] v);
        logic [3:0] p;
        p = 4'h0;
        for (int k = 0; k < AVG_W; k++) begin
            if (v[k]) begin
                p = 4'(k);
            end
        end
        return p;
    endfunction

    // log2 as octave index plus four-bit mantissa, scaled to half-dB steps
    always_comb begin
        msb = msb_pos(avg);
        norm = avg << (4'(AVG_W - 1) - msb);
        mant = norm[AVG_W-2 -: 4];
        frac = 8'((8'(mant) * 8'(DB_STEPS_PER_OCTAVE)) >> 4);
        gain_comp = 8'(8'(gain) * 8'(GAIN_STEP_HALF_DB));
        strength_nxt = strength_r;
        out_valid_nxt = in_valid;
        if (in_valid) begin
            if (avg == '0) begin
                strength_nxt = gain_comp;
            end else begin
                strength_nxt = 8'(8'(msb) * 8'(DB_STEPS_PER_OCTAVE)) + frac + gain_comp;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            out_valid_r <= 1'b0;
            strength_r <= 8'h00;
        end else begin
            out_valid_r <= out_valid_nxt;
            strength_r <= strength_nxt;
        end
    end

    assign out_valid = out_valid_r;
    assign strength = strength_r;

    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);

    chk_half_db_scale: assert property (
        in_valid && avg == 13'h0400 && gain == 2'h0 |=> out_valid && strength == 8'd120)
        else $error("octave scale is not 12 half-dB steps");
    chk_gain_offset: assert property (
        in_valid && avg == 13'h0400 && gain == 2'h3 |=> strength == 8'd147)
        else $error("gain of -13.5 dB not compensated by 27 steps");
endmodule

// >>> design/rse_pkg.sv
// Functional notes
// - on-off keying: sixteen I/Q samples per low-IF period; the code paces them by the programmed deviation period instead.
// - frequency-shift keying: sixteen I/Q samples per programmed deviation period.
// - strength is the average over a sliding window of the latest 16 samples.
// - readable strength value is refreshed once per sample.
// - one step of the strength value is 0.5 dB, uncalibrated.
// - IF gain selectable 0 to -13.5 dB in 4.5 dB steps, resets to 0 dB.
// - alarm raised when the strength rises above the programmed alarm level.
// - alarm recorded in a flag; writing one clears it, zero leaves it.
// - receive interrupt routed to pin a or pin b by per-pin selects.
// - estimator runs only while the operating mode field holds 011.
package rse_pkg;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int IQ_W = 12;
    localparam int MAG_W = IQ_W + 1;
    localparam int WIN_DEPTH = 16;
    localparam int WIN_AW = 4;
    localparam int SUM_W = MAG_W + WIN_AW;
    localparam int SAMPLES_PER_PERIOD = 16;
    localparam int XTAL_CYC_PER_DEV_STEP = 32;
    localparam int DB_STEPS_PER_OCTAVE = 12;
    localparam int GAIN_STEP_HALF_DB = 9;

    localparam logic [ADDR_W-1:0] REG_CTRL = 8'h00;
    localparam logic [ADDR_W-1:0] REG_DEVIATION = 8'h04;
    localparam logic [ADDR_W-1:0] REG_ALARM_LEVEL = 8'h08;
    localparam logic [ADDR_W-1:0] REG_STATUS = 8'h0c;
    localparam logic [ADDR_W-1:0] REG_MASK = 8'h10;
    localparam logic [ADDR_W-1:0] REG_ROUTE = 8'h14;
    localparam logic [ADDR_W-1:0] REG_STRENGTH = 8'h18;

    localparam int CTRL_MODE_LSB = 0;
    localparam int CTRL_OOK_BIT = 3;
    localparam int CTRL_GAIN_LSB = 4;
    localparam int STATUS_ALARM_BIT = 0;
    localparam int ROUTE_LINE0_BIT = 0;
    localparam int ROUTE_LINE1_BIT = 1;

    localparam logic [2:0] MODE_RX = 3'h3;
    localparam logic [2:0] MODE_RESET = 3'h0;
    localparam logic [1:0] GAIN_RESET = 2'h0;
    localparam logic [7:0] DEV_RESET = 8'h03;
    localparam logic [7:0] ALARM_LEVEL_RESET = 8'h00;
endpackage

// >>> design/rse_ring_mem.sv
module rse_ring_mem #(
    parameter int W = 13,
    parameter int DEPTH = 16,
    parameter int AW = 4
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic wr_en,
    input wire logic [AW-1:0] wr_addr,
    input wire logic [W-1:0] wr_data,
    input wire logic [AW-1:0] rd_addr,
    output logic [W-1:0] rd_data
);
    logic [W-1:0] mem [DEPTH];
    logic [W-1:0] rd_data_r;
    logic [W-1:0] rd_data_nxt;

    always_comb begin
        rd_data_nxt = mem[rd_addr];
    end

    always_ff @(posedge pclk) begin
        if (wr_en) begin
            mem[wr_addr] <= wr_data;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rd_data_r <= '0;
        end else begin
            rd_data_r <= rd_data_nxt;
        end
    end

    assign rd_data = rd_data_r;
endmodule

// >>> design/rse_top.sv
module rse_top #(
    parameter int CLK_PER_XTAL = 16
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [rse_pkg::ADDR_W-1:0] paddr,
    input wire logic [rse_pkg::DATA_W-1:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic pready,
    output logic [rse_pkg::DATA_W-1:0] prdata,
    output logic pslverr,
    input wire logic signed [rse_pkg::IQ_W-1:0] baseband_i,
    input wire logic signed [rse_pkg::IQ_W-1:0] baseband_q,
    output logic [1:0] if_gain_code,
    output logic rx_active,
    output logic [7:0] signal_strength_value,
    output logic irq,
    output logic interrupt_pin_a,
    output logic interrupt_pin_b
);
    import rse_pkg::*;

    // register state
    logic [2:0] mode_r, mode_nxt;
    logic ook_r, ook_nxt;
    logic [1:0] gain_r, gain_nxt;
    logic [7:0] dev_r, dev_nxt;
    logic [7:0] level_r, level_nxt;
    logic flag_r, flag_nxt;
    logic mask_r, mask_nxt;
    logic line0_r, line0_nxt;
    logic line1_r, line1_nxt;
    logic pready_r, pready_nxt;
    logic [DATA_W-1:0] prdata_r, prdata_nxt;
    logic pslverr_r, pslverr_nxt;
    // estimator state
    logic [15:0] samp_cnt_r, samp_cnt_nxt;
    logic [MAG_W-1:0] mag_r, mag_nxt;
    logic phase1_r, phase1_nxt;
    logic avg_valid_r, avg_valid_nxt;
    logic [SUM_W-1:0] sum_r, sum_nxt;
    logic [WIN_AW-1:0] ptr_r, ptr_nxt;
    logic [4:0] fill_r, fill_nxt;
    logic [7:0] strength_r, strength_nxt;
    // output flops
    logic irq_r, irq_nxt;
    logic pin_a_r, pin_a_nxt;
    logic pin_b_r, pin_b_nxt;
    logic rx_active_r, rx_active_nxt;

    logic setup;
    logic wr_en;
    logic mapped;
    logic rx_on;
    logic samp_tick;
    logic [15:0] interval;
    logic [IQ_W-1:0] abs_i;
    logic [IQ_W-1:0] abs_q;
    logic [MAG_W-1:0] old_v;
    logic [MAG_W-1:0] rd_data;
    logic lc_valid;
    logic [7:0] lc_strength;
    logic alarm_set;
    logic alarm_clr;
    logic pending;

    function automatic logic is_mapped(input logic [ADDR_W-1:0] a);
        return a == REG_CTRL || a == REG_DEVIATION || a == REG_ALARM_LEVEL ||
               a == REG_STATUS || a == REG_MASK || a == REG_ROUTE || a == REG_STRENGTH;
    endfunction

    // apb slave: zero wait states, read data and error registered in setup
    always_comb begin
        setup = psel && !penable;
        wr_en = psel && penable && pready_r && pwrite && pstrb[0];
        mapped = is_mapped(paddr);
        pready_nxt = 1'b1;
        prdata_nxt = prdata_r;
        pslverr_nxt = pslverr_r;
        if (setup) begin
            pslverr_nxt = !mapped;
            prdata_nxt = '0;
            case (paddr)
                REG_CTRL: begin
                    prdata_nxt[CTRL_MODE_LSB +: 3] = mode_r;
                    prdata_nxt[CTRL_OOK_BIT] = ook_r;
                    prdata_nxt[CTRL_GAIN_LSB +: 2] = gain_r;
                end
                REG_DEVIATION: prdata_nxt[7:0] = dev_r;
                REG_ALARM_LEVEL: prdata_nxt[7:0] = level_r;
                REG_STATUS: prdata_nxt[STATUS_ALARM_BIT] = flag_r;
                REG_MASK: prdata_nxt[STATUS_ALARM_BIT] = mask_r;
                REG_ROUTE: begin
                    prdata_nxt[ROUTE_LINE0_BIT] = line0_r;
                    prdata_nxt[ROUTE_LINE1_BIT] = line1_r;
                end
                REG_STRENGTH: prdata_nxt[7:0] = strength_r;
                default: prdata_nxt = '0;
            endcase
        end
    end

    // configuration registers
    always_comb begin
        mode_nxt = mode_r;
        ook_nxt = ook_r;
        gain_nxt = gain_r;
        dev_nxt = dev_r;
        level_nxt = level_r;
        mask_nxt = mask_r;
        line0_nxt = line0_r;
        line1_nxt = line1_r;
        if (wr_en) begin
            case (paddr)
                REG_CTRL: begin
                    mode_nxt = pwdata[CTRL_MODE_LSB +: 3];
                    ook_nxt = pwdata[CTRL_OOK_BIT];
                    gain_nxt = pwdata[CTRL_GAIN_LSB +: 2];
                end
                REG_DEVIATION: dev_nxt = pwdata[7:0];
                REG_ALARM_LEVEL: level_nxt = pwdata[7:0];
                REG_MASK: mask_nxt = pwdata[STATUS_ALARM_BIT];
                REG_ROUTE: begin
                    line0_nxt = pwdata[ROUTE_LINE0_BIT];
                    line1_nxt = pwdata[ROUTE_LINE1_BIT];
                end
                default: begin
                end
            endcase
        end
    end

    // sample pacing: interval is one sixteenth of the deviation period
    always_comb begin
        rx_on = mode_r == MODE_RX;
        interval = 16'((16'(dev_r) + 16'h0001) *
                   16'(XTAL_CYC_PER_DEV_STEP / SAMPLES_PER_PERIOD * CLK_PER_XTAL));
        samp_tick = rx_on && samp_cnt_r == 16'h0000;
        if (!rx_on || samp_tick) begin
            samp_cnt_nxt = interval - 16'h0001;
        end else begin
            samp_cnt_nxt = samp_cnt_r - 16'h0001;
        end
    end

    // sliding window of the last sixteen magnitudes
    always_comb begin
        abs_i = baseband_i[IQ_W-1] ? 12'(-baseband_i) : 12'(baseband_i);
        abs_q = baseband_q[IQ_W-1] ? 12'(-baseband_q) : 12'(baseband_q);
        mag_nxt = samp_tick ? {1'b0, abs_i} + {1'b0, abs_q} : mag_r;
        old_v = (fill_r == 5'(WIN_DEPTH)) ? rd_data : '0;
        phase1_nxt = samp_tick;
        avg_valid_nxt = phase1_r && rx_on;
        sum_nxt = sum_r;
        ptr_nxt = ptr_r;
        fill_nxt = fill_r;
        if (!rx_on) begin
            sum_nxt = '0;
            ptr_nxt = '0;
            fill_nxt = 5'h00;
        end else if (phase1_r) begin
            sum_nxt = sum_r + SUM_W'(mag_r) - SUM_W'(old_v);
            ptr_nxt = ptr_r + 4'h1;
            if (fill_r != 5'(WIN_DEPTH)) begin
                fill_nxt = fill_r + 5'h01;
            end
        end
    end

    rse_ring_mem #(.W(MAG_W), .DEPTH(WIN_DEPTH), .AW(WIN_AW)) u_win (
        .pclk(pclk),
        .presetn(presetn),
        .wr_en(phase1_r && rx_on),
        .wr_addr(ptr_r),
        .wr_data(mag_r),
        .rd_addr(ptr_r),
        .rd_data(rd_data)
    );

    rse_log_conv #(.AVG_W(MAG_W)) u_log (
        .pclk(pclk),
        .presetn(presetn),
        .in_valid(avg_valid_r),
        .avg(sum_r[SUM_W-1 -: MAG_W]),
        .gain(gain_r),
        .out_valid(lc_valid),
        .strength(lc_strength)
    );

    // strength, alarm flag and interrupt outputs
    always_comb begin
        strength_nxt = lc_valid ? lc_strength : strength_r;
        alarm_set = lc_valid && rx_on && lc_strength > level_r;
        alarm_clr = wr_en && paddr == REG_STATUS && pwdata[STATUS_ALARM_BIT];
        if (alarm_set) begin
            flag_nxt = 1'b1;
        end else if (alarm_clr) begin
            flag_nxt = 1'b0;
        end else begin
            flag_nxt = flag_r;
        end
        pending = flag_r && mask_r;
        irq_nxt = pending;
        pin_a_nxt = pending && line0_r;
        pin_b_nxt = pending && line1_r;
        rx_active_nxt = rx_on;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mode_r <= MODE_RESET;
            ook_r <= 1'b0;
            gain_r <= GAIN_RESET;
            dev_r <= DEV_RESET;
            level_r <= ALARM_LEVEL_RESET;
            flag_r <= 1'b0;
            mask_r <= 1'b0;
            line0_r <= 1'b0;
            line1_r <= 1'b0;
            pready_r <= 1'b0;
            prdata_r <= '0;
            pslverr_r <= 1'b0;
            samp_cnt_r <= 16'h0000;
            mag_r <= '0;
            phase1_r <= 1'b0;
            avg_valid_r <= 1'b0;
            sum_r <= '0;
            ptr_r <= '0;
            fill_r <= 5'h00;
            strength_r <= 8'h00;
            irq_r <= 1'b0;
            pin_a_r <= 1'b0;
            pin_b_r <= 1'b0;
            rx_active_r <= 1'b0;
        end else begin
            mode_r <= mode_nxt;
            ook_r <= ook_nxt;
            gain_r <= gain_nxt;
            dev_r <= dev_nxt;
            level_r <= level_nxt;
            flag_r <= flag_nxt;
            mask_r <= mask_nxt;
            line0_r <= line0_nxt;
            line1_r <= line1_nxt;
            pready_r <= pready_nxt;
            prdata_r <= prdata_nxt;
            pslverr_r <= pslverr_nxt;
            samp_cnt_r <= samp_cnt_nxt;
            mag_r <= mag_nxt;
            phase1_r <= phase1_nxt;
            avg_valid_r <= avg_valid_nxt;
            sum_r <= sum_nxt;
            ptr_r <= ptr_nxt;
            fill_r <= fill_nxt;
            strength_r <= strength_nxt;
            irq_r <= irq_nxt;
            pin_a_r <= pin_a_nxt;
            pin_b_r <= pin_b_nxt;
            rx_active_r <= rx_active_nxt;
        end
    end

    assign pready = pready_r;
    assign prdata = prdata_r;
    assign pslverr = pslverr_r;
    assign if_gain_code = gain_r;
    assign rx_active = rx_active_r;
    assign signal_strength_value = strength_r;
    assign irq = irq_r;
    assign interrupt_pin_a = pin_a_r;
    assign interrupt_pin_b = pin_b_r;

    // helper: cycles since the last sample, valid only with a steady interval
    logic [15:0] gap_r;
    logic gap_ok_r;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            gap_r <= 16'h0000;
            gap_ok_r <= 1'b0;
        end else begin
            gap_r <= samp_tick ? 16'h0001 : gap_r + 16'h0001;
            if (!rx_on || (wr_en && paddr == REG_DEVIATION)) begin
                gap_ok_r <= 1'b0;
            end else if (samp_tick) begin
                gap_ok_r <= 1'b1;
            end
        end
    end

    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence seq_sample_kept;
        samp_tick ##1 rx_on;
    endsequence
    sequence seq_refreshed;
        ##2 lc_valid ##1 (signal_strength_value == $past(lc_strength));
    endsequence

    chk_ook_sample_rate: assert property (
        samp_tick && gap_ok_r && ook_r |-> gap_r == interval)
        else $error("on-off sample spacing wrong");
    chk_fsk_sample_rate: assert property (
        samp_tick && gap_ok_r && !ook_r |-> gap_r == interval)
        else $error("frequency-shift sample spacing wrong");
    chk_window_restart: assert property (
        !rx_on |=> sum_r == '0 && fill_r == 5'h00 && fill_r <= 5'(WIN_DEPTH))
        else $error("window not emptied outside receive");
    chk_refresh_per_sample: assert property (
        seq_sample_kept |-> seq_refreshed)
        else $error("strength not refreshed three cycles after a kept sample");
    chk_alarm_raise: assert property (
        lc_valid && rx_on && lc_strength > level_r |=> flag_r ##1 (irq || !$past(mask_r)))
        else $error("alarm not raised above the level");
    chk_alarm_w1c: assert property (
        alarm_clr && !alarm_set |=> !flag_r)
        else $error("write of one did not clear the alarm");
    chk_alarm_sticky: assert property (
        flag_r && !alarm_clr |=> flag_r)
        else $error("alarm flag dropped without a clear");
    chk_pin_route: assert property (
        flag_r && mask_r && line0_r && !line1_r |=> interrupt_pin_a && !interrupt_pin_b)
        else $error("interrupt not routed to the selected pin");
    chk_rx_gate: assert property (
        (!rx_on)[*4] |-> $stable(signal_strength_value) && !avg_valid_r)
        else $error("strength changed outside receive mode");
endmodule

// >>> verification/rse_host_model.sv
module rse_host_model (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [7:0] signal_strength_value,
    output int changes,
    output int gap
);
    import rse_pkg::*;
    int cyc;
    int last;
    logic [7:0] prev;

    // host polls the strength value every cycle and notes the spacing of its updates
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cyc <= 0;
            last <= 0;
            changes <= 0;
            gap <= 0;
            prev <= 8'h00;
        end else begin
            cyc <= cyc + 1;
            prev <= signal_strength_value;
            if (signal_strength_value !== prev) begin
                changes <= changes + 1;
                gap <= cyc - last;
                last <= cyc;
            end
        end
    end
endmodule

// >>> verification/rssi_estimator_with_threshold_irq_tb.sv
`define CHK(got, exp) begin \
    num_checks++; \
    if ((got) !== (exp)) begin \
        errors++; \
        $display("mismatch at %0t: got %h expected %h", $time, got, exp); \
    end \
end

module rssi_estimator_with_threshold_irq_tb;
    timeunit 1ns;
    timeprecision 100ps;
    import rse_pkg::*;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [ADDR_W-1:0] paddr;
    logic [DATA_W-1:0] pwdata, prdata;
    logic [3:0] pstrb;
    logic signed [IQ_W-1:0] bb_i, bb_q;
    logic [1:0] if_gain_code;
    logic rx_active, irq, interrupt_pin_a, interrupt_pin_b;
    logic [7:0] signal_strength_value;
    int changes, gap, errors, num_checks, cycles;

    rse_top #(.CLK_PER_XTAL(1)) u_dut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(pready), .prdata(prdata),
        .pslverr(pslverr), .baseband_i(bb_i), .baseband_q(bb_q),
        .if_gain_code(if_gain_code), .rx_active(rx_active),
        .signal_strength_value(signal_strength_value), .irq(irq),
        .interrupt_pin_a(interrupt_pin_a), .interrupt_pin_b(interrupt_pin_b)
    );
    rse_host_model u_host (
        .pclk(pclk), .presetn(presetn), .signal_strength_value(signal_strength_value),
        .changes(changes), .gap(gap)
    );

    initial begin
        pclk = 1'b0;
        forever #2.5 pclk = ~pclk;
    end

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask

    always @(posedge pclk) begin
        cycles++;
        if (cycles == 20000) begin
            errors++;
            give_verdict();
        end
    end

    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] rd, output logic er);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] rd;
        logic er;
        apb(1'b1, a, d, rd, er);
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input logic exp_er);
        logic [31:0] rd;
        logic er;
        apb(1'b0, a, 32'h0, rd, er);
        `CHK(rd, exp)
        `CHK(er, exp_er)
    endtask

    task automatic wait_changes(input int n);
        int c0, k;
        c0 = changes;
        k = 0;
        while (changes < c0 + n && k < 2000) begin
            @(posedge pclk);
            k++;
        end
        `CHK(k < 2000, 1'b1)
    endtask

    task automatic t_reset();
        rd_chk(REG_CTRL, 32'h0, 1'b0);
        rd_chk(REG_DEVIATION, 32'(DEV_RESET), 1'b0);
        rd_chk(REG_ALARM_LEVEL, 32'h0, 1'b0);
        rd_chk(REG_STATUS, 32'h0, 1'b0);
        rd_chk(REG_MASK, 32'h0, 1'b0);
        rd_chk(REG_ROUTE, 32'h0, 1'b0);
        rd_chk(REG_STRENGTH, 32'h0, 1'b0);
        rd_chk(8'h1c, 32'h0, 1'b1);
        `CHK(if_gain_code, 2'h0)
        `CHK(rx_active, 1'b0)
        $display("test reset done");
    endtask

    task automatic t_rate();
        logic [7:0] held;
        for (int ook = 1; ook >= 0; ook--) begin
            wr(REG_DEVIATION, ook ? 32'h3 : 32'h1);
            wr(REG_CTRL, ook ? 32'hb : 32'h3);
            wait_changes(4);
            `CHK(gap, ook ? 8 : 4)
            `CHK(rx_active, 1'b1)
            wr(REG_CTRL, 32'h0);
            repeat (3) @(posedge pclk);
            held = signal_strength_value;
            repeat (20) @(posedge pclk);
            `CHK(signal_strength_value, held)
            `CHK(rx_active, 1'b0)
        end
        $display("test rate done");
    endtask

    task automatic t_window();
        wr(REG_DEVIATION, 32'h0);
        wr(REG_CTRL, 32'h3);
        wait_changes(16);
        `CHK(signal_strength_value, 8'd120)
        for (int g = 1; g <= 4; g++) begin
            wr(REG_CTRL, 32'((g % 4) << 4) | 32'h3);
            @(posedge pclk);
            `CHK(if_gain_code, 2'(g % 4))
            wait_changes(1);
            `CHK(signal_strength_value, 8'(120 + 9 * (g % 4)))
        end
        bb_i <= 12'sh000;
        bb_q <= 12'sh000;
        wait_changes(8);
        `CHK(signal_strength_value, 8'd108)
        `CHK(gap, 2)
        wait_changes(8);
        `CHK(signal_strength_value, 8'd0)
        $display("test window done");
    endtask

    task automatic t_alarm();
        wr(REG_STATUS, 32'h1);
        rd_chk(REG_STATUS, 32'h0, 1'b0);
        wr(REG_ALARM_LEVEL, 32'd120);
        wr(REG_MASK, 32'h1);
        wr(REG_ROUTE, 32'h1);
        bb_i <= -12'sh200;
        bb_q <= 12'sh200;
        wait_changes(16);
        repeat (10) @(posedge pclk);
        rd_chk(REG_STATUS, 32'h0, 1'b0);
        `CHK(irq, 1'b0)
        wr(REG_ALARM_LEVEL, 32'd119);
        repeat (10) @(posedge pclk);
        rd_chk(REG_STATUS, 32'h1, 1'b0);
        `CHK(irq, 1'b1)
        for (int r = 0; r < 4; r++) begin
            wr(REG_ROUTE, 32'(r));
            repeat (3) @(posedge pclk);
            `CHK(interrupt_pin_a, 1'(r & 1))
            `CHK(interrupt_pin_b, 1'(r >> 1))
        end
        wr(REG_MASK, 32'h0);
        repeat (3) @(posedge pclk);
        `CHK(irq, 1'b0)
        wr(REG_MASK, 32'h1);
        bb_i <= 12'sh000;
        bb_q <= 12'sh000;
        wait_changes(16);
        rd_chk(REG_STATUS, 32'h1, 1'b0);
        wr(REG_STATUS, 32'h0);
        rd_chk(REG_STATUS, 32'h1, 1'b0);
        wr(REG_STATUS, 32'h1);
        rd_chk(REG_STATUS, 32'h0, 1'b0);
        repeat (3) @(posedge pclk);
        `CHK(irq, 1'b0)
        $display("test alarm done");
    endtask

    initial begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        pstrb = 4'hf;
        bb_i = -12'sh200;
        bb_q = 12'sh200;
        errors = 0;
        num_checks = 0;
        cycles = 0;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        t_reset();
        t_rate();
        t_window();
        t_alarm();
        give_verdict();
    end
endmodule
